// *** rtl/pwm_softstart_fault_sequencer.sv ***
// Start-up and protection sequencer of a three-phase buck controller.
// Assumes async comparator levels and an oscillator tick from another
// domain; all of them are synchronised here.
// Hysteresis of enable, undervoltage and overvoltage sits in the analog
// comparators; every decision lags the pins by three clocks.
`timescale 1ns/1ps
module pwm_softstart_fault_sequencer (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// Release conditions
	input wire logic threshold_enable_in,
	input wire logic bias_supply_ok,
	input wire logic first_driver_supply,
	input wire logic second_driver_supply,
	input wire logic third_driver_supply,
	input wire logic [1:0] phases_used_m1,
	input wire logic ref_select_lsb,
	input wire logic ref_select_msb,
	// Time base and comparators
	input wire logic switch_tick,
	input wire seq_pkg::comp_t comp_in,
	// PWM request from the modulator
	input wire logic [seq_pkg::PHASES-1:0] pwm_req,
	// Outputs
	output seq_pkg::gate_t [seq_pkg::PHASES-1:0] gate_out,
	output logic power_ok_out_oe,
	output logic [11:0] ramp_level,
	output logic [9:0] sense_offset,
	output logic soft_start_active
);
	// ==================================================
	// Input synchronisers
	localparam int unsigned NSYNC = 12 + $bits(seq_pkg::comp_t)
		+ seq_pkg::PHASES - 2;
	logic [NSYNC-1:0] raw_w;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	assign raw_w = {threshold_enable_in, bias_supply_ok, first_driver_supply,
		second_driver_supply, third_driver_supply, phases_used_m1,
		ref_select_lsb, ref_select_msb, switch_tick, comp_in, pwm_req};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else if (clk_en) begin
			s1_q <= raw_w;
			s2_q <= s1_q;
		end
	end

	wire en_s = s2_q[NSYNC-1];
	wire bias_s = s2_q[NSYNC-2];
	wire drv1_s = s2_q[NSYNC-3];
	wire drv2_s = s2_q[NSYNC-4];
	wire drv3_s = s2_q[NSYNC-5];
	wire [1:0] nph_s = s2_q[NSYNC-6 -: 2];
	wire [1:0] refsel_s = {s2_q[NSYNC-9], s2_q[NSYNC-8]};
	wire tick_lvl_s = s2_q[NSYNC-10];
	seq_pkg::comp_t cmp_s;
	assign cmp_s = s2_q[seq_pkg::PHASES +: $bits(seq_pkg::comp_t)];
	wire [seq_pkg::PHASES-1:0] pwm_s = s2_q[seq_pkg::PHASES-1:0];

	// ==================================================
	// Decode
	logic tick_prev_q;
	// Idle tick level is low, so no false edge follows reset
	wire tick_w = tick_lvl_s & ~tick_prev_q;
	wire one_phase_w = nph_s == 2'h0;
	wire three_phase_w = nph_s == 2'h2;
	// Unused driver supplies are not required for release
	wire drv2_ok_w = drv2_s | one_phase_w;
	wire drv3_ok_w = drv3_s | !three_phase_w;
	wire drv_ok_w = drv1_s & drv2_ok_w & drv3_ok_w;
	wire release_w = en_s & bias_s & drv_ok_w;
	logic [11:0] ramp_end_w;
	assign ramp_end_w = refsel_s == 2'h0 ? seq_pkg::RAMP_0P6 :
		refsel_s == 2'h1 ? seq_pkg::RAMP_0P9 :
		refsel_s == 2'h2 ? seq_pkg::RAMP_1P2 :
		seq_pkg::RAMP_1P5;

	seq_pkg::state_t state_q, state_d;
	logic [11:0] cnt_q, cnt_d;
	logic [11:0] ss_cnt_q, ss_cnt_d;
	logic drives_on_q, drives_on_d;
	logic soft_done_q, soft_done_d;

	// ==================================================
	// Fault decode
	// Fixed level guards the delay, ramp and hiccup phases; in run ref+150mV alone trips
	wire ov_fixed_w = cmp_s.ov_fixed_trip & ~soft_done_q;
	// Release points of both levels come from the comparators
	wire ov_w = cmp_s.ov_ref_trip | ov_fixed_w;
	wire uv_w = cmp_s.undervolt;
	wire oc_w = cmp_s.overcurrent;
	wire open_w = cmp_s.open_sense;
	wire fault_w = ov_w | uv_w | oc_w;
	// A trip while already waiting does not restart the wait
	wire oc_trip_w = state_q != seq_pkg::ST_SHUTDOWN
		&& state_q != seq_pkg::ST_HICCUP && oc_w;
	wire stop_w = !release_w || open_w;

	// ==================================================
	// Phase timing
	wire in_ss_w = state_q == seq_pkg::ST_DELAY
		|| state_q == seq_pkg::ST_RAMP;
	wire delay_end_w = state_q == seq_pkg::ST_DELAY && tick_w
		&& cnt_q == seq_pkg::DELAY_LAST;
	wire ramp_done_w = state_q == seq_pkg::ST_RAMP && tick_w
		&& cnt_q >= ramp_end_w - 12'h1;
	wire hiccup_end_w = state_q == seq_pkg::ST_HICCUP && tick_w
		&& cnt_q == seq_pkg::HICCUP_LAST;

	// ==================================================
	// Sequencer
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (tick_w) begin
			cnt_d = cnt_q + 12'h1;
		end
		case (state_q)
			seq_pkg::ST_SHUTDOWN: begin
				cnt_d = 12'h0;
				if (!stop_w) begin
					state_d = seq_pkg::ST_DELAY;
				end
			end
			seq_pkg::ST_DELAY: begin
				if (delay_end_w) begin
					state_d = seq_pkg::ST_RAMP;
					cnt_d = 12'h0;
				end
			end
			seq_pkg::ST_RAMP: begin
				if (ramp_done_w) begin
					state_d = seq_pkg::ST_RUN;
					cnt_d = 12'h0;
				end
			end
			seq_pkg::ST_RUN: begin
				cnt_d = 12'h0;
			end
			seq_pkg::ST_HICCUP: begin
				if (hiccup_end_w) begin
					state_d = seq_pkg::ST_DELAY;
					cnt_d = 12'h0;
				end
			end
			default: begin
				state_d = seq_pkg::ST_SHUTDOWN;
				cnt_d = 12'h0;
			end
		endcase
		// Overcurrent wait counts from zero on a trip outside shutdown and hiccup
		if (oc_trip_w) begin
			state_d = seq_pkg::ST_HICCUP;
			cnt_d = 12'h0;
		end
		// Disable and open sense win; the restart is a full one
		if (stop_w) begin
			state_d = seq_pkg::ST_SHUTDOWN;
			cnt_d = 12'h0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= seq_pkg::ST_SHUTDOWN;
			cnt_q <= 12'h0;
			tick_prev_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			tick_prev_q <= tick_lvl_s;
		end
	end

	// ==================================================
	// Soft-start bookkeeping: offset ramp, drive enable, completion
	// Shutdown and hiccup both start the next soft-start from scratch
	wire ss_clear_w = state_d == seq_pkg::ST_SHUTDOWN
		|| state_d == seq_pkg::ST_HICCUP;
	// Offset ramp counts from the start of the ramp phase
	wire ofs_step_w = state_q == seq_pkg::ST_RAMP && tick_w
		&& ss_cnt_q != seq_pkg::OFFSET_LAST;
	// Ramp has caught up with the feedback level
	wire caught_w = state_q == seq_pkg::ST_RAMP
		&& !cmp_s.fb_above_ramp;
	assign ss_cnt_d = ss_clear_w ? 12'h0 :
		ofs_step_w ? ss_cnt_q + 12'h1 : ss_cnt_q;
	// Pre-charged above target: drives wait for the end of the ramp
	assign drives_on_d = !ss_clear_w
		&& (drives_on_q || caught_w || ramp_done_w);
	assign soft_done_d = !ss_clear_w
		&& (soft_done_q || ramp_done_w);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ss_cnt_q <= 12'h0;
			drives_on_q <= 1'b0;
			soft_done_q <= 1'b0;
		end else if (clk_en) begin
			ss_cnt_q <= ss_cnt_d;
			drives_on_q <= drives_on_d;
			soft_done_q <= soft_done_d;
		end
	end

	// ==================================================
	// Gate commands, one generate branch per phase
	wire active_w = state_q != seq_pkg::ST_SHUTDOWN;
	wire hiccup_w = state_q == seq_pkg::ST_HICCUP;
	// Clamp overrides the high-Z hold and the overcurrent switch-off
	wire ov_force_w = active_w & ov_w;
	wire run_drive_w = drives_on_q & !hiccup_w;
	genvar p;
	generate
		for (p = 0; p < seq_pkg::PHASES; p++) begin : g_phase
			logic [2:0] gate_d;
			assign gate_d = ov_force_w ? 3'b011 :
				run_drive_w ? {pwm_s[p], ~pwm_s[p], 1'b1} :
				hiccup_w ? 3'b001 :
				3'b000;
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					gate_out[p] <= '0;
				end else if (clk_en) begin
					gate_out[p] <= gate_d;
				end
			end
		end
	endgenerate

	// ==================================================
	// Power-good and monitor outputs
	// Undervoltage only lowers power-good; the sequence ignores it
	wire power_ok_out_w = soft_done_q && state_q == seq_pkg::ST_RUN
		&& !fault_w;
	logic [11:0] ramp_w;
	assign ramp_w = state_q == seq_pkg::ST_RAMP ? cnt_q :
		state_q == seq_pkg::ST_RUN ? ramp_end_w : 12'h0;
	logic [9:0] offset_w;
	assign offset_w = seq_pkg::OFFSET_FULL - ss_cnt_q[9:0];
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			power_ok_out_oe <= 1'b1;
			ramp_level <= 12'h0;
			sense_offset <= seq_pkg::OFFSET_FULL;
			soft_start_active <= 1'b0;
		end else if (clk_en) begin
			power_ok_out_oe <= ~power_ok_out_w;
			ramp_level <= ramp_w;
			sense_offset <= offset_w;
			soft_start_active <= in_ss_w;
		end
	end
endmodule : pwm_softstart_fault_sequencer

// *** shared/seq_pkg.sv ***
// Constants and carrier types for the soft-start and fault sequencer.
// Assumes analog comparators deliver digital levels and a tick per period.
// Contract
// - In shutdown every phase PWM output is held high impedance.
// - Stay in shutdown until threshold enable is high; low means disable.
// - Release needs bias and first driver supply good, plus used others.
// - All release conditions true starts soft-start immediately.
// - Wait 64 cycles, then ramp reference at 1280 cycles per volt.
// - Outputs stay high impedance until ramp reaches output voltage.
// - 100mV sense offset ramps to zero over first 640 soft-start cycles. Code ramps it over the first 640 ramp cycles, after the 64-cycle wait.
// - Feedback above ramp holds both switches off; enable when ramp exceeds.
// - Output pre-charged above target enables drives at soft-start end.
// - Power-good low in shutdown, released only after soft-start completes.
// - Power-good low on undervoltage, overvoltage, overcurrent or disable.
// - Undervoltage only drops power-good; comparator hysteresis 82 to 85 pct.
// - Soft-start OV trip is max of ref+150mV and 1.67V; later ref+150mV. Code trips on either level in soft-start.
// - OV releases 50mV below ref trip, 100mV below fixed trip.
// - Overvoltage forces all low gates high and power-good low until clear.
// - After overvoltage ends, switching and power-good resume without restart.
// - Local sense above amp output plus 1V shuts down, then restarts.
// - Overcurrent flagged when load line voltage exceeds overcurrent set.
// - Overcurrent turns all switches off for 4096 switching cycles.
// - Still enabled after the wait, retry soft-start without limit.
// - Reference select 00..11 gives 0.600, 0.900, 1.200, 1.500 V.
package seq_pkg;
	// ==================================================
	// Timing counts in switching cycles
	localparam int unsigned DELAY_CYCLES = 64;
	localparam int unsigned CYCLES_PER_VOLT = 1280;
	localparam int unsigned OFFSET_RAMP_CYCLES = 640;
	localparam int unsigned HICCUP_CYCLES = 4096;
	localparam logic [11:0] DELAY_LAST = 12'(DELAY_CYCLES - 1);
	localparam logic [11:0] HICCUP_LAST = 12'(HICCUP_CYCLES - 1);
	// Ramp length per target: volts times cycles per volt (0.6/0.9/1.2/1.5)
	localparam logic [11:0] RAMP_0P6 = 12'(CYCLES_PER_VOLT * 6 / 10);
	localparam logic [11:0] RAMP_0P9 = 12'(CYCLES_PER_VOLT * 9 / 10);
	localparam logic [11:0] RAMP_1P2 = 12'(CYCLES_PER_VOLT * 12 / 10);
	localparam logic [11:0] RAMP_1P5 = 12'(CYCLES_PER_VOLT * 15 / 10);
	localparam logic [11:0] OFFSET_LAST = 12'(OFFSET_RAMP_CYCLES);
	// Reset value of the sense offset code, full scale = 100mV
	localparam logic [9:0] OFFSET_FULL = 10'h280;
	localparam int unsigned PHASES = 3;

	typedef enum logic [2:0] {
		ST_SHUTDOWN,
		ST_DELAY,
		ST_RAMP,
		ST_RUN,
		ST_HICCUP
	} state_t;

	// Comparator levels from the analog front end
	typedef struct packed {
		logic fb_above_ramp;    // feedback_in above ramping reference
		logic out_above_target; // output pre-charged above final reference
		logic undervolt;        // output below 82/85 pct window
		logic ov_ref_trip;      // above ref+150mV, released 50mV lower
		logic ov_fixed_trip;    // above 1.67V, released 100mV lower
		logic open_sense;       // local_output_sense above amp out + 1V
		logic overcurrent;      // load_line_voltage above overcurrent_set_in
	} comp_t;

	// Gate commands for one phase
	typedef struct packed {
		logic high_side_gate;
		logic low_side_gate;
		logic drive_en;         // low: outputs high impedance
	} gate_t;
endpackage : seq_pkg

// *** tb/seq_asserts.sv ***
// Port assertions for the soft-start and fault sequencer.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/1ps
module seq_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Watched inputs
	input wire logic threshold_enable_in,
	input wire logic first_driver_supply,
	input wire seq_pkg::comp_t comp_in,
	// Watched outputs
	input wire seq_pkg::gate_t [seq_pkg::PHASES-1:0] gate_out,
	input wire logic power_ok_out_oe,
	input wire logic [11:0] ramp_level,
	input wire logic [9:0] sense_offset,
	input wire logic soft_start_active
);
	// ==================================================
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire logic [2:0] lows = {gate_out[2].low_side_gate,
		gate_out[1].low_side_gate, gate_out[0].low_side_gate};
	AST_OFF_HIZ: assert property (
		(!threshold_enable_in)[*5] |-> gate_out == '0)
		else $error("outputs driven while disabled");
	AST_NO_SUPPLY: assert property (
		(!first_driver_supply)[*5] |-> !soft_start_active)
		else $error("soft-start without driver supply");
	AST_START: assert property (
		$rose(soft_start_active) |->
		ramp_level == 12'h000 && sense_offset == 10'h280)
		else $error("soft-start not from zero with full offset");
	AST_RAMP_STEP: assert property (
		soft_start_active && $past(soft_start_active) &&
		ramp_level != $past(ramp_level) |->
		ramp_level == $past(ramp_level) + 12'h001)
		else $error("ramp not linear");
	AST_OFS_STEP: assert property (
		soft_start_active && $past(soft_start_active) &&
		sense_offset != $past(sense_offset) |->
		sense_offset == $past(sense_offset) - 10'h001)
		else $error("offset not ramping down");
	AST_PG_SS: assert property (
		soft_start_active |-> power_ok_out_oe)
		else $error("power good released in soft-start");
	AST_PG_OC: assert property (
		comp_in.overcurrent[*6] |-> power_ok_out_oe)
		else $error("power good high on overcurrent");
	AST_PG_UV: assert property (
		comp_in.undervolt[*6] |-> power_ok_out_oe)
		else $error("power good high on undervoltage");
	AST_OV_LOWS: assert property (
		(comp_in.ov_ref_trip && soft_start_active)[*5] |-> lows == 3'h7)
		else $error("low gates not forced on overvoltage");
endmodule : seq_asserts

bind pwm_softstart_fault_sequencer seq_asserts seq_asserts_inst (.clock,
	.rst, .threshold_enable_in, .first_driver_supply, .comp_in, .gate_out,
	.power_ok_out_oe, .ramp_level, .sense_offset, .soft_start_active);

// *** tb/stage_model.sv ***
// Far-side model: switching oscillator and power-good pull-up.
// Assumes the bench clock; one switching period is four clocks.
`timescale 1ns/1ps
module stage_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Pin side
	input wire logic power_ok_out_oe,
	output logic switch_tick,
	output logic power_ok_line
);
	// ==================================================
	// Oscillator, two clocks high and two low
	logic [1:0] div_q;
	// Pulled up unless the device sinks it
	assign power_ok_line = !power_ok_out_oe;
	assign switch_tick = div_q[1];
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
endmodule : stage_model

// *** tb/tb_top.sv ***
// Self-checking bench for the soft-start and fault sequencer.
// Assumes the stage model ticks every four clocks.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [1:0] sel;
		logic [11:0] ramp_end;
		logic pre;
	} row_t;
	row_t rows [4] = '{'{2'h0, 12'h300, 1'b0}, '{2'h1, 12'h480, 1'b1},
		'{2'h2, 12'h600, 1'b0}, '{2'h3, 12'h780, 1'b1}};
	logic clock = 1'b0, rst = 1'b1, en = 1'b0, sup1 = 1'b1, sup2 = 1'b1;
	logic bias = 1'b1, sup3 = 1'b1;
	logic [1:0] sel = 2'h0, ph = 2'h2;
	seq_pkg::comp_t comp = '0;
	seq_pkg::gate_t [seq_pkg::PHASES-1:0] gate;
	logic oe, ssa, tick, pg, early;
	logic [11:0] ramp, top;
	logic [9:0] offs;
	int error_cnt = 0, n_compared = 0, n;
	always #12.5 clock = ~clock;
	stage_model stage_model_inst (.clock, .rst, .power_ok_out_oe(oe),
		.switch_tick(tick), .power_ok_line(pg));
	pwm_softstart_fault_sequencer pwm_softstart_fault_sequencer_inst (
		.clock, .rst, .clk_en(1'b1), .threshold_enable_in(en),
		.bias_supply_ok(bias), .first_driver_supply(sup1),
		.second_driver_supply(sup2), .third_driver_supply(sup3),
		.phases_used_m1(ph), .ref_select_lsb(sel[0]),
		.ref_select_msb(sel[1]), .switch_tick(tick), .comp_in(comp),
		.pwm_req(3'h5), .gate_out(gate), .power_ok_out_oe(oe),
		.ramp_level(ramp), .sense_offset(offs), .soft_start_active(ssa));
	// ==================================================
	// Ramp monitor; guard keeps the ramp-end handover out
	always @(negedge clock) begin
		if (ssa && gate[0].drive_en && ramp < 12'h2F0) early = 1'b1;
		if (ramp > top) top = ramp;
	end
	task automatic chk(input string what, input logic [11:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask : cyc
	task automatic wait_ssa(input logic v, input int lim);
		n = 0;
		while (ssa !== v && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			error_cnt++;
			test_done();
		end
	endtask : wait_ssa
	task automatic step(input seq_pkg::comp_t v);
		@(posedge clock);
		comp <= v;
		cyc(8);
	endtask : step
	// ==================================================
	// Main sequence
	initial begin
		early = 1'b0;
		top = 12'h000;
		cyc(2);
		chk("reset gates", 12'(gate), 12'h000);
		chk("reset pg", 12'(oe), 12'h001);
		chk("reset offset", 12'(offs), 12'h280);
		@(posedge clock);
		rst <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clock);
			en <= 1'b0;
			cyc(8);
			chk("off gates", 12'(gate), 12'h000);
			chk("off pg", 12'(pg), 12'h000);
			@(posedge clock);
			sel <= rows[i].sel;
			comp.fb_above_ramp <= rows[i].pre;
			comp.out_above_target <= rows[i].pre;
			en <= 1'b1;
			wait_ssa(1'b1, 20);
			early = 1'b0;
			top = 12'h000;
			wait_ssa(1'b0, 9000);
			cyc(1);
			chk("ramp end", top, rows[i].ramp_end);
			chk("offset end", 12'(offs), 12'h000);
			chk("drive early", 12'(early), 12'(!rows[i].pre));
			cyc(8);
			chk("pg high", 12'(pg), 12'h001);
			chk("drive on", 12'(gate[0].drive_en), 12'h001);
			chk("run gates", 12'(gate), 12'h15D);
			step(7'h00);
		end
		step(7'h10);
		chk("uv pg", 12'(pg), 12'h000);
		chk("uv drive", 12'({ssa, gate[0].drive_en}), 12'h001);
		step(7'h00);
		chk("uv clear pg", 12'(pg), 12'h001);
		step(7'h04);
		chk("fixed ov run", 12'(pg), 12'h001);
		step(7'h01);
		chk("oc gates", 12'(gate), 12'h049);
		chk("oc pg", 12'(pg), 12'h000);
		step(7'h00);
		wait_ssa(1'b1, 17000);
		chk("hiccup", 12'(n > 16300 && n < 16400), 12'h001);
		step(7'h08);
		chk("ov gates", 12'(gate), 12'h0DB);
		chk("ov pg", 12'(pg), 12'h000);
		step(7'h00);
		chk("ov end", 12'({ssa, gate}), 12'h200);
		step(7'h04);
		chk("fixed ov ss", 12'(gate), 12'h0DB);
		step(7'h00);
		step(7'h02);
		chk("open sense", 12'({ssa, gate}), 12'h000);
		step(7'h00);
		chk("sense restart", 12'({ssa, offs}), 12'h680);
		@(posedge clock);
		sup1 <= 1'b0;
		cyc(8);
		chk("no supply1", 12'(ssa), 12'h000);
		@(posedge clock);
		sup1 <= 1'b1;
		sup2 <= 1'b0;
		cyc(8);
		chk("no supply2", 12'(ssa), 12'h000);
		@(posedge clock);
		ph <= 2'h0;
		cyc(8);
		chk("one phase", 12'(ssa), 12'h001);
		@(posedge clock);
		ph <= 2'h1;
		cyc(8);
		chk("two phase no supply2", 12'(ssa), 12'h000);
		@(posedge clock);
		sup2 <= 1'b1;
		sup3 <= 1'b0;
		cyc(8);
		chk("two phase no supply3", 12'(ssa), 12'h001);
		@(posedge clock);
		ph <= 2'h2;
		cyc(8);
		chk("no supply3", 12'(ssa), 12'h000);
		@(posedge clock);
		sup3 <= 1'b1;
		bias <= 1'b0;
		cyc(8);
		chk("no bias", 12'(ssa), 12'h000);
		test_done();
	end
endmodule : tb_top
